// ===== pht_cfg.svh
/*
 * Timing counts, bus addresses, command codes and field layout for the
 * sensor command port.
 * Assumes a 10 MHz system clock and an included-once header.
 */
`ifndef PHT_CFG_SVH
`define PHT_CFG_SVH

`define PHT_CLK_PERIOD_NS  100
`define PHT_HRST_TIME_NS   15000000
`define PHT_HRST_CYCLES    (`PHT_HRST_TIME_NS / `PHT_CLK_PERIOD_NS)
`define PHT_CONV_CYCLES    1000

`define PHT_ADDR_PT        7'h76
`define PHT_ADDR_HUM       7'h40

`define PHT_CMD_CONV_P     8'h48
`define PHT_CMD_CONV_T     8'h58
`define PHT_CMD_ADC_RD     8'h00
`define PHT_CMD_HRST       8'hfe
`define PHT_CMD_UREG_RD    8'he7
`define PHT_CMD_UREG_WR    8'he6

`define PHT_UREG_RST       8'h02
`define PHT_UREG_HEATER    8'h04
`define PHT_UREG_RES8      8'h01

`define PHT_BITS_BYTE      4'h8
`define PHT_WORD_W         24
`define PHT_HCNT_W         18
`define PHT_CCNT_W         16

`endif

// ===== pht_conv.sv
/*
 * Conversion engine: runs a fixed-length conversion of the raw pressure or
 * temperature word and holds the result.
 * Assumes the raw words come from an analog front end in the clk domain.
 */
`include "pht_cfg.svh"

module pht_conv #(
    parameter int CONV_CYCLES = `PHT_CONV_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   start,
    input  wire logic                   sel,
    input  wire logic                   corrupt,
    input  wire logic [`PHT_WORD_W-1:0] raw_pressure_word,
    input  wire logic [`PHT_WORD_W-1:0] raw_temperature_word,
    output logic                        busy,
    output logic                        done,
    output logic [`PHT_WORD_W-1:0]      result
);

    pht_pkg::pht_conv_t s;
    pht_pkg::pht_conv_t n;
    logic [`PHT_WORD_W-1:0] word;

    always_comb begin
        n = s;
        n.done = 1'b0;
        word = s.sel ? raw_temperature_word : raw_pressure_word;
        if (start) begin
            n.busy = 1'b1;
            n.sel = sel;
            n.bad = 1'b0;
            n.cnt = `PHT_CCNT_W'(CONV_CYCLES - 1);
        end else if (s.busy) begin
            // Busy until done; a read meanwhile spoils the result
            if (corrupt) begin
                n.bad = 1'b1;
            end
            if (s.cnt == '0) begin
                n.busy = 1'b0;
                n.done = 1'b1;
                n.res = (s.bad || corrupt) ? ~word : word;
            end else begin
                n.cnt = s.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign busy   = s.busy;
    assign done   = s.done;
    assign result = s.res;

endmodule : pht_conv

// ===== pht_i2c_port.sv
/*
 * Two-address bus slave of the combined sensor: conversion command, result
 * read, humidity reset and user register access.
 * Assumes scl and sda are already synchronous to clk and slow against it.
 */
`include "pht_cfg.svh"

module pht_i2c_port #(
    parameter int HRST_CYCLES = `PHT_HRST_CYCLES,
    parameter int CONV_CYCLES = `PHT_CONV_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   scl_i,
    input  wire logic                   sda_i,
    output logic                        sda_o,
    output logic                        sda_oe_n,
    input  wire logic [`PHT_WORD_W-1:0] raw_pressure_word,
    input  wire logic [`PHT_WORD_W-1:0] raw_temperature_word,
    output logic                        conv_busy,
    output logic                        hum_resetting,
    output logic [7:0]                  hum_user_reg,
    output logic                        hum_res8
);

    pht_pkg::pht_port_t s;
    pht_pkg::pht_port_t n;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   bus_start;
    logic                   bus_stop;
    logic                   byte_in;
    logic [6:0]             addr;
    logic                   conv_start;
    logic                   conv_sel;
    logic                   conv_corrupt;
    logic                   conv_done;
    logic [`PHT_WORD_W-1:0] conv_res;
    logic                   res_ready;

    assign scl_rise  = scl_i && !s.scl_q;
    assign scl_fall  = !scl_i && s.scl_q;
    assign bus_start = scl_i && s.scl_q && s.sda_q && !sda_i;
    assign bus_stop  = scl_i && s.scl_q && !s.sda_q && sda_i;
    assign byte_in   = scl_fall && s.bits == `PHT_BITS_BYTE;
    assign addr      = s.sh[7:1];
    assign res_ready = (s.res_ok || conv_done) && !conv_busy;

    pht_conv #(
        .CONV_CYCLES          (CONV_CYCLES)
    ) u_conv (
        .clk                  (clk),
        .nrst                 (nrst),
        .start                (conv_start),
        .sel                  (conv_sel),
        .corrupt              (conv_corrupt),
        .raw_pressure_word    (raw_pressure_word),
        .raw_temperature_word (raw_temperature_word),
        .busy                 (conv_busy),
        .done                 (conv_done),
        .result               (conv_res)
    );

    always_comb begin
        n = s;
        n.scl_q = scl_i;
        n.sda_q = sda_i;
        conv_start = 1'b0;
        conv_sel = 1'b0;
        conv_corrupt = 1'b0;
        if (conv_done) begin
            n.res_ok = 1'b1;
        end
        // Humidity reboot timer
        if (s.hrst) begin
            if (s.hcnt == '0) begin
                n.hrst = 1'b0;
            end else begin
                n.hcnt = s.hcnt - 1'b1;
            end
        end
        if (bus_start) begin
            n.st = pht_pkg::PHT_ADDR;
            n.bits = '0;
            n.nbyte = '0;
            n.drv = 1'b0;
        end else if (bus_stop) begin
            n.st = pht_pkg::PHT_IDLE;
            n.drv = 1'b0;
        end else begin
            case (s.st)
                pht_pkg::PHT_ADDR, pht_pkg::PHT_WBIT: begin
                    if (scl_rise) begin
                        n.sh = {s.sh[6:0], sda_i};
                        n.bits = s.bits + 1'b1;
                    end else if (byte_in && s.st == pht_pkg::PHT_ADDR) begin
                        n.bits = '0;
                        n.rd = s.sh[0];
                        if (addr == `PHT_ADDR_PT) begin
                            n.hum = 1'b0;
                            n.drv = 1'b1;
                            n.st = pht_pkg::PHT_AACK;
                        end else if (addr == `PHT_ADDR_HUM && !s.hrst) begin
                            n.hum = 1'b1;
                            n.drv = 1'b1;
                            n.st = pht_pkg::PHT_AACK;
                        end else begin
                            n.st = pht_pkg::PHT_IDLE;
                        end
                    end else if (byte_in) begin
                        n.bits = '0;
                        n.drv = 1'b1;
                        n.st = pht_pkg::PHT_WACK;
                        if (s.nbyte != 2'h3) begin
                            n.nbyte = s.nbyte + 1'b1;
                        end
                        if (s.nbyte == 2'h0) begin
                            n.cmd = s.sh;
                            if (!s.hum) begin
                                if (s.sh == `PHT_CMD_CONV_P ||
                                    s.sh == `PHT_CMD_CONV_T) begin
                                    conv_start = 1'b1;
                                    conv_sel = s.sh == `PHT_CMD_CONV_T;
                                    n.res_ok = 1'b0;
                                end else if (s.sh == `PHT_CMD_ADC_RD) begin
                                    // Result once, zero otherwise
                                    n.tx = res_ready ?
                                           conv_res : '0;
                                    n.res_ok = 1'b0;
                                    conv_corrupt = conv_busy;
                                end
                            end else if (s.sh == `PHT_CMD_HRST) begin
                                n.ureg = (`PHT_UREG_RST & ~`PHT_UREG_HEATER) |
                                         (s.ureg & `PHT_UREG_HEATER);
                                n.hrst = 1'b1;
                                n.hcnt = `PHT_HCNT_W'(HRST_CYCLES - 1);
                            end else if (s.sh == `PHT_CMD_UREG_RD) begin
                                n.tx = {s.ureg, 16'h0000};
                            end
                        end else if (s.nbyte == 2'h1 && s.hum &&
                                     s.cmd == `PHT_CMD_UREG_WR) begin
                            n.ureg = s.sh;
                        end
                    end
                end
                pht_pkg::PHT_AACK: begin
                    if (scl_fall) begin
                        if (s.rd) begin
                            n.drv = !s.tx[`PHT_WORD_W-1];
                            n.st = pht_pkg::PHT_RBIT;
                        end else begin
                            n.drv = 1'b0;
                            n.st = pht_pkg::PHT_WBIT;
                        end
                    end
                end
                pht_pkg::PHT_WACK: begin
                    if (scl_fall) begin
                        n.drv = 1'b0;
                        n.st = pht_pkg::PHT_WBIT;
                    end
                end
                pht_pkg::PHT_RBIT: begin
                    if (scl_rise) begin
                        n.bits = s.bits + 1'b1;
                    end else if (byte_in) begin
                        n.bits = '0;
                        n.drv = 1'b0;
                        n.st = pht_pkg::PHT_RACK;
                    end else if (scl_fall) begin
                        n.tx = {s.tx[`PHT_WORD_W-2:0], 1'b0};
                        n.drv = !s.tx[`PHT_WORD_W-2];
                    end
                end
                pht_pkg::PHT_RACK: begin
                    if (scl_rise && sda_i) begin
                        n.st = pht_pkg::PHT_IDLE;
                    end else if (scl_fall) begin
                        n.tx = {s.tx[`PHT_WORD_W-2:0], 1'b0};
                        n.drv = !s.tx[`PHT_WORD_W-2];
                        n.st = pht_pkg::PHT_RBIT;
                    end
                end
                default: begin
                    n.drv = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.ureg <= `PHT_UREG_RST;
            s.scl_q <= 1'b1;
            s.sda_q <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Open-drain: only ever pulls low
    assign sda_o         = 1'b0;
    assign sda_oe_n      = !s.drv;
    assign hum_resetting = s.hrst;
    assign hum_user_reg  = s.ureg;
    assign hum_res8      = s.ureg[0] && !s.ureg[7];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_stop_idle: assert property (
        bus_stop |=> s.st == pht_pkg::PHT_IDLE && sda_oe_n)
        else $error("stop did not return port to idle");
    a_pt_addr_ack: assert property (
        s.st == pht_pkg::PHT_ADDR && byte_in && !bus_start && !bus_stop &&
        addr == `PHT_ADDR_PT |=> !sda_oe_n)
        else $error("pressure address not acknowledged");
    a_hum_addr_ack: assert property (
        s.st == pht_pkg::PHT_ADDR && byte_in && !bus_start && !bus_stop &&
        addr == `PHT_ADDR_HUM |=> !sda_oe_n == !$past(s.hrst))
        else $error("humidity address answer wrong");
    a_conv_starts: assert property (
        conv_start |=> conv_busy)
        else $error("conversion command did not start conversion");
    a_busy_until: assert property (
        $fell(conv_busy) |-> conv_done)
        else $error("busy dropped without completion");
    a_read_busy_zero: assert property (
        conv_corrupt |=> s.tx == '0)
        else $error("read during conversion not zero");
    a_read_twice_zero: assert property (
        s.st == pht_pkg::PHT_WBIT && byte_in && !s.hum &&
        s.nbyte == 2'h0 && s.sh == `PHT_CMD_ADC_RD && !s.res_ok &&
        !conv_done && !bus_stop && !bus_start |=>
        s.tx == '0 && !s.res_ok)
        else $error("stale read did not return zero");
    a_heater_kept: assert property (
        s.hum && s.st == pht_pkg::PHT_WBIT && byte_in && s.nbyte == 2'h0 &&
        s.sh == `PHT_CMD_HRST && !bus_stop && !bus_start |=>
        hum_resetting && (s.ureg & `PHT_UREG_HEATER) ==
        ($past(s.ureg) & `PHT_UREG_HEATER))
        else $error("humidity reset lost heater bit");
    a_nack_release: assert property (
        s.st == pht_pkg::PHT_RACK && scl_rise && sda_i && !bus_start &&
        !bus_stop |=> s.st == pht_pkg::PHT_IDLE)
        else $error("nack did not end read");
    a_ack_bit_wait: assert property (
        s.st == pht_pkg::PHT_RBIT && byte_in && !bus_start && !bus_stop |=>
        s.st == pht_pkg::PHT_RACK && sda_oe_n)
        else $error("port did not release for acknowledge");

    c_conv_done: cover property (conv_start ##[1:1000] conv_done);
    c_result_read: cover property (s.st == pht_pkg::PHT_RACK && s.res_ok == 1'b0);
    c_hum_reset: cover property ($rose(hum_resetting));
    c_ureg_write: cover property ($changed(s.ureg) && !hum_resetting);

endmodule : pht_i2c_port

// ===== pht_master_model.sv
/*
 * Bus master model: drives SCL and the master side of SDA.
 * Assumes the bench resolves the SDA wire with a pull-up.
 */
module pht_master_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // One bit, SDA moves only while SCL low
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        scl <= 1'b0;
        tick(2);
        sda_m <= b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        r = sda;
        tick(2);
    endtask : bit_io

    task automatic start_c();
        tick(1);
        scl <= 1'b0;
        tick(2);
        sda_m <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b0;
        tick(4);
    endtask : start_c

    task automatic stop_c();
        tick(1);
        scl <= 1'b0;
        tick(2);
        sda_m <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b1;
        tick(4);
    endtask : stop_c

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    // Write frame of n data bytes, stop even when refused
    task automatic xfer_wr(input logic [6:0] a, input logic [15:0] d,
                           input int n, output logic ack);
        logic k;
        start_c();
        wr_byte({a, 1'b0}, ack);
        for (int i = n - 1; i >= 0 && ack; i--) begin
            wr_byte(d[8*i +: 8], k);
            ack = ack & k;
        end
        stop_c();
    endtask : xfer_wr

    // Read n bytes, ack all but the last, then stop
    task automatic rd_word(input logic [6:0] a, input int n,
                           output logic [23:0] w, output logic ack);
        logic [7:0] b;
        logic       r;
        w = 24'h000000;
        start_c();
        wr_byte({a, 1'b1}, ack);
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
            bit_io(k == n - 1, r);
            w = {w[15:0], b};
        end
        stop_c();
    endtask : rd_word
endmodule : pht_master_model

// ===== pht_pkg.sv
/*
 * State types for the sensor command port and its conversion engine.
 * Assumes pht_cfg.svh is on the include path.
 */
`include "pht_cfg.svh"

package pht_pkg;

    typedef enum logic [2:0] {
        PHT_IDLE = 3'b000,
        PHT_ADDR = 3'b001,
        PHT_AACK = 3'b010,
        PHT_WBIT = 3'b011,
        PHT_WACK = 3'b100,
        PHT_RBIT = 3'b101,
        PHT_RACK = 3'b110
    } pht_st_t;

    typedef struct packed {
        pht_st_t                  st;
        logic [3:0]               bits;
        logic [7:0]               sh;
        logic                     hum;
        logic                     rd;
        logic [1:0]               nbyte;
        logic [7:0]               cmd;
        logic                     drv;
        logic [`PHT_WORD_W-1:0]   tx;
        logic                     res_ok;
        logic [7:0]               ureg;
        logic                     hrst;
        logic [`PHT_HCNT_W-1:0]   hcnt;
        logic                     scl_q;
        logic                     sda_q;
    } pht_port_t;

    typedef struct packed {
        logic                     busy;
        logic                     sel;
        logic                     bad;
        logic [`PHT_CCNT_W-1:0]   cnt;
        logic                     done;
        logic [`PHT_WORD_W-1:0]   res;
    } pht_conv_t;

endpackage : pht_pkg

// ===== pht_sensor_i2c_command_port_bench.sv
/*
 * Self-checking bench for the sensor command port.
 * Assumes pht_cfg.svh, pht_i2c_port and pht_master_model are compiled.
 */
`include "pht_cfg.svh"

module pht_sensor_i2c_command_port_bench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int CONV = 800;
    localparam int HRST = 400;

    logic        clk, nrst, scl, sda_m, sda, sda_o, sda_oe_n;
    logic        conv_busy, hum_resetting, hum_res8, ack;
    logic [7:0]  hum_user_reg, v;
    logic [23:0] p_word, t_word, w;
    logic [6:0]  a;
    int          num_errors, compares, n;

    assign sda = sda_m & (sda_oe_n | sda_o);
    always #50 clk = ~clk;

    pht_i2c_port #(.HRST_CYCLES(HRST), .CONV_CYCLES(CONV)) DUT (
        .clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .raw_pressure_word(p_word), .raw_temperature_word(t_word),
        .conv_busy(conv_busy), .hum_resetting(hum_resetting),
        .hum_user_reg(hum_user_reg), .hum_res8(hum_res8)
    );

    pht_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));

    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] after_hrst(input logic [7:0] old);
        return (`PHT_UREG_RST & ~`PHT_UREG_HEATER) | (old & `PHT_UREG_HEATER);
    endfunction : after_hrst

    // Eight-bit resolution: bit 0 set, bit 7 clear
    function automatic logic res8_exp(input logic [7:0] u);
        return (u & 8'h81) == 8'h01;
    endfunction : res8_exp

    task automatic give_verdict();
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic adc_read(output logic [23:0] r);
        m.xfer_wr(`PHT_ADDR_PT, 16'(`PHT_CMD_ADC_RD), 1, ack);
        m.rd_word(`PHT_ADDR_PT, 3, r, ack);
    endtask : adc_read

    task automatic convert(input logic [7:0] cmd);
        m.xfer_wr(`PHT_ADDR_PT, 16'(cmd), 1, ack);
        check("conv ack", 24'(ack), 24'h1);
        check("busy", 24'(conv_busy), 24'h1);
    endtask : convert

    // Remaining busy time must lie above lo and within one conversion
    task automatic wait_conv(input int lo);
        n = 0;
        while (conv_busy === 1'b1 && n < CONV + 10) begin
            @(posedge clk);
            n++;
        end
        check("busy len", 24'(n <= CONV && n > lo), 24'h1);
    endtask : wait_conv

    task automatic ureg_read(output logic [23:0] r);
        m.start_c();
        m.wr_byte({`PHT_ADDR_HUM, 1'b0}, ack);
        m.wr_byte(`PHT_CMD_UREG_RD, ack);
        m.rd_word(`PHT_ADDR_HUM, 1, r, ack);
    endtask : ureg_read

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        give_verdict();
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        p_word = 24'h000000;
        t_word = 24'h000000;
        void'($urandom(58237));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        check("ureg rst", 24'(hum_user_reg), 24'(`PHT_UREG_RST));
        check("oe idle", 24'(sda_oe_n), 24'h1);
        check("sda_o", 24'(sda_o), 24'h0);
        adc_read(w);
        check("read no conv", w, 24'h0);
        repeat (4) begin
            a = 7'($urandom);
            if (a == `PHT_ADDR_PT || a == `PHT_ADDR_HUM) begin
                a = a ^ 7'h01;
            end
            m.xfer_wr(a, 16'h0000, 1, ack);
            check("foreign addr", 24'(ack), 24'h0);
        end
        for (int k = 0; k < 4; k++) begin
            p_word <= (k == 0) ? 24'h800001 : 24'($urandom);
            t_word <= (k == 1) ? 24'h000080 : 24'($urandom);
            convert(k[0] ? `PHT_CMD_CONV_T : `PHT_CMD_CONV_P);
            wait_conv(CONV - 60);
            adc_read(w);
            check("result", w, k[0] ? t_word : p_word);
            adc_read(w);
            check("second read", w, 24'h0);
        end
        convert(`PHT_CMD_CONV_P);
        adc_read(w);
        check("read busy", w, 24'h0);
        check("still busy", 24'(conv_busy), 24'h1);
        wait_conv(CONV - 600);
        adc_read(w);
        check("corrupted", w, ~p_word);
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? `PHT_UREG_RES8 : (k == 1) ? 8'($urandom) : 8'h05;
            m.xfer_wr(`PHT_ADDR_HUM, {`PHT_CMD_UREG_WR, v}, 2, ack);
            check("ureg wr ack", 24'(ack), 24'h1);
            check("ureg", 24'(hum_user_reg), 24'(v));
            check("res8", 24'(hum_res8), 24'(res8_exp(v)));
            ureg_read(w);
            check("ureg rd", w, 24'(v));
        end
        m.xfer_wr(`PHT_ADDR_HUM, 16'(`PHT_CMD_HRST), 1, ack);
        check("hrst busy", 24'(hum_resetting), 24'h1);
        m.xfer_wr(`PHT_ADDR_HUM, 16'(`PHT_CMD_UREG_RD), 1, ack);
        check("nack in reset", 24'(ack), 24'h0);
        n = 0;
        while (hum_resetting === 1'b1 && n < HRST) begin
            @(posedge clk);
            n++;
        end
        check("hrst done", 24'(hum_resetting), 24'h0);
        check("heater", 24'(hum_user_reg), 24'(after_hrst(v)));
        ureg_read(w);
        check("hum addr", w, 24'(after_hrst(v)));
        give_verdict();
    end
endmodule : pht_sensor_i2c_command_port_bench
